/* File: verilog/mpa_params.svh */
// Register map, field positions and reset values of the pin allocator.
// Included by the allocator alone, not by its helpers; definitions only.
`ifndef MPA_PARAMS_SVH
`define MPA_PARAMS_SVH

`define MPA_ADDR_CLKSEL 4'h0
`define MPA_ADDR_GPIOFN 4'h1
`define MPA_ADDR_MISOFN 4'h2
`define MPA_ADDR_SCLKFN 4'h3
`define MPA_ADDR_DINFN 4'h4
`define MPA_ADDR_DIR 4'h5
`define MPA_ADDR_GPOLVL 4'h6
`define MPA_ADDR_GPILVL 4'h7
`define MPA_ADDR_STATUS 4'h8
`define MPA_ADDR_W 4

`define MPA_CC_LSB 0
`define MPA_CC_MSB 1
`define MPA_PL_LSB 2
`define MPA_PL_MSB 3
`define MPA_FN_LSB 0
`define MPA_GPIOFN_MSB 3
`define MPA_MISOFN_MSB 2
`define MPA_SCLKFN_MSB 2
`define MPA_DINFN_MSB 1
`define MPA_DIR_BCLK 0
`define MPA_DIR_WCLK 1
`define MPA_GPO1 0
`define MPA_GPO2 1
`define MPA_GPI1 0
`define MPA_GPI2 1
`define MPA_GPI3 2
`define MPA_ST_CC_OK 0
`define MPA_ST_PL_OK 1

`define MPA_RST_MASTER 1'h0
`define MPA_RST_GPO 2'h0
`define MPA_RD_IDLE 8'h00
`define MPA_NUM_GPI 3

`endif

/* File: verilog/mpa_pkg.sv */
// Types of the multifunction pin allocator: source selects and pin modes.
// Field codes follow the declaration order, from zero.
package mpa_pkg;
	typedef enum logic [1:0] {MPA_CC_MCLK, MPA_CC_BCLK, MPA_CC_GPIO, MPA_CC_PLL} mpa_cc_src_t;
	typedef enum logic [1:0] {MPA_PL_MCLK, MPA_PL_BCLK, MPA_PL_DIN, MPA_PL_GPIO} mpa_pl_src_t;
	typedef enum logic [3:0] {
		MPA_GP_OFF, MPA_GP_CLKIN, MPA_GP_GPOUT, MPA_GP_GPIN, MPA_GP_IRQ_FIRST, MPA_GP_IRQ_SECOND,
		MPA_GP_SBCLKO, MPA_GP_SWCLKO, MPA_GP_AUXCLK, MPA_GP_SBCLKI, MPA_GP_SWCLKI, MPA_GP_SDIN
	} mpa_gpio_fn_t;
	typedef enum logic [2:0] {
		MPA_MS_CTRL, MPA_MS_GPOUT, MPA_MS_IRQ_FIRST, MPA_MS_IRQ_SECOND,
		MPA_MS_SBCLKO, MPA_MS_SWCLKO, MPA_MS_SDOUT, MPA_MS_AUXCLK
	} mpa_miso_fn_t;
	typedef enum logic [2:0] {
		MPA_SC_CTRL, MPA_SC_GPIN, MPA_SC_SBCLKI, MPA_SC_SWCLKI, MPA_SC_SDIN
	} mpa_sclk_fn_t;
	typedef enum logic [1:0] {MPA_DI_AUDIO, MPA_DI_GPIN, MPA_DI_CLKIN} mpa_din_fn_t;
endpackage : mpa_pkg

/* File: verilog/mpa_ref_sel.sv */
// Registered selector feeding one internal reference clock from a candidate pin.
// Candidates are sampled as synchronous inputs; an unusable source yields a quiet zero.
`timescale 1ns/1ps
`default_nettype none
module mpa_ref_sel import mpa_pkg::*; #(
	parameter int N = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [N-1:0] cand,
	input wire logic [$clog2(N)-1:0] sel,
	input wire logic srcOk,
	output logic refOut
);
	initial begin
		if (N < 2) $error("mpa_ref_sel needs at least two candidates");
	end

	// Gating a bad source avoids clocking converters from a pin busy elsewhere
	always_ff @(posedge core_clk) begin
		if (rst) refOut <= 1'b0;
		else refOut <= srcOk & cand[sel];
	end
endmodule : mpa_ref_sel
`default_nettype wire

/* File: verilog/mpa_gp_in.sv */
// Level capture of the general-purpose inputs, one bit per allocated pin.
// A bit reads zero while its pin serves some other function.
`timescale 1ns/1ps
`default_nettype none
module mpa_gp_in import mpa_pkg::*; #(
	parameter int N = 3
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [N-1:0] pinLvl,
	input wire logic [N-1:0] pinEn,
	output logic [N-1:0] level
);
	initial begin
		if (N < 1 || N > 8) $error("mpa_gp_in supports one to eight inputs");
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_ff @(posedge core_clk) begin
				if (rst) level[i] <= 1'b0;
				else level[i] <= pinEn[i] & pinLvl[i];
			end
		end
	endgenerate
endmodule : mpa_gp_in
`default_nettype wire

/* File: verilog/mpa_pin_allocator.sv */
// Multifunction digital pin allocator: routes pins to internal functions.
// Assumes pins are synchronous to core_clk; the core supplies sources.
// Function
// - PLL reference selectable from master clock, bit clock, data input or GPIO pin.
// - Master clock pin may feed PLL and converter clock together.
// - Bit clock pin may feed PLL, converter clock and audio bit clock together.
// - GPIO pin may feed PLL and converter clock together.
// - A pin holding an exclusive function carries no other function.
// - GPIO as general output never also carries the first interrupt.
// - Reset defaults: master clock to converter, bit, word, data pins to audio port.
// - GPIO pin may be an exclusive output driven from a register level.
// - Control data-out pin may be an exclusive second general output.
// - Data input pin may be an exclusive first general input, readable.
// - GPIO pin may be an exclusive second general input.
// - Control serial clock pin may be an exclusive third general input.
// - Secondary data out only on data-out pin; secondary clocks on GPIO or data-out.
// - Two-bit field picks converter clock: master, bit clock, GPIO or PLL output.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mpa_params.svh"
module mpa_pin_allocator import mpa_pkg::*; #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [AW-1:0] regAddr,
	input wire logic [DW-1:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [DW-1:0] regRdData,
	input wire logic mclkIn,
	input wire logic bclkIn,
	output logic bclkOut,
	output logic bclkOe,
	input wire logic wclkIn,
	output logic wclkOut,
	output logic wclkOe,
	input wire logic dinIn,
	input wire logic gpioIn,
	output logic gpioOut,
	output logic gpioOe,
	input wire logic sclkIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic pllOutClk,
	input wire logic masterBclk,
	input wire logic masterWclk,
	input wire logic ctrlMisoData,
	input wire logic ctrlMisoOe,
	input wire logic firstIntr,
	input wire logic secondIntr,
	input wire logic secBclkSrc,
	input wire logic secWclkSrc,
	input wire logic secDoutSrc,
	input wire logic auxClk,
	output logic pllRefClk,
	output logic convRefClk,
	output logic audioBclk,
	output logic audioWclk,
	output logic audioDin,
	output logic spiSclk,
	output logic secBclkIn,
	output logic secWclkIn,
	output logic secDinIn
);
	initial begin
		if (AW < `MPA_ADDR_W || DW < 8) $error("mpa_pin_allocator needs AW>=4 and DW>=8");
	end

	mpa_cc_src_t ccSel_r;
	mpa_pl_src_t plSel_r;
	mpa_gpio_fn_t gpioFn_r;
	mpa_miso_fn_t misoFn_r;
	mpa_sclk_fn_t sclkFn_r;
	mpa_din_fn_t dinFn_r;
	logic bclkMst_r;
	logic wclkMst_r;
	logic [1:0] gpoLvl_r;
	logic [`MPA_NUM_GPI-1:0] gpiLvl;
	logic addrHit;
	logic [`MPA_ADDR_W-1:0] addrLo;
	logic ccOk;
	logic plOk;
	logic gpioOut_nxt;
	logic gpioOe_nxt;
	logic misoOut_nxt;
	logic misoOe_nxt;
	logic [DW-1:0] rdMux;

	assign addrLo = regAddr[`MPA_ADDR_W-1:0];
	// Upper address bits must be zero so aliases never hit a register
	assign addrHit = (regAddr >> `MPA_ADDR_W) == '0;

	// Configuration written by software; one field per pin keeps each pin single-use
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ccSel_r <= MPA_CC_MCLK;
			plSel_r <= MPA_PL_MCLK;
			gpioFn_r <= MPA_GP_OFF;
			misoFn_r <= MPA_MS_CTRL;
			sclkFn_r <= MPA_SC_CTRL;
			dinFn_r <= MPA_DI_AUDIO;
			bclkMst_r <= `MPA_RST_MASTER;
			wclkMst_r <= `MPA_RST_MASTER;
			gpoLvl_r <= `MPA_RST_GPO;
		end else if (regWrEn && addrHit) begin
			case (addrLo)
				`MPA_ADDR_CLKSEL: begin
					ccSel_r <= mpa_cc_src_t'(regWrData[`MPA_CC_MSB:`MPA_CC_LSB]);
					plSel_r <= mpa_pl_src_t'(regWrData[`MPA_PL_MSB:`MPA_PL_LSB]);
				end
				`MPA_ADDR_GPIOFN: gpioFn_r <= mpa_gpio_fn_t'(regWrData[`MPA_GPIOFN_MSB:`MPA_FN_LSB]);
				`MPA_ADDR_MISOFN: misoFn_r <= mpa_miso_fn_t'(regWrData[`MPA_MISOFN_MSB:`MPA_FN_LSB]);
				`MPA_ADDR_SCLKFN: sclkFn_r <= mpa_sclk_fn_t'(regWrData[`MPA_SCLKFN_MSB:`MPA_FN_LSB]);
				`MPA_ADDR_DINFN: dinFn_r <= mpa_din_fn_t'(regWrData[`MPA_DINFN_MSB:`MPA_FN_LSB]);
				`MPA_ADDR_DIR: begin
					bclkMst_r <= regWrData[`MPA_DIR_BCLK];
					wclkMst_r <= regWrData[`MPA_DIR_WCLK];
				end
				`MPA_ADDR_GPOLVL: gpoLvl_r <= regWrData[`MPA_GPO2:`MPA_GPO1];
				default: ;
			endcase
		end
	end

	// Master clock and PLL output are always usable; GPIO and data pins only in clock-input mode, bit clock only while not master
	always_comb begin
		unique case (plSel_r)
			MPA_PL_MCLK: plOk = 1'b1;
			MPA_PL_BCLK: plOk = !bclkMst_r;
			MPA_PL_DIN: plOk = dinFn_r == MPA_DI_CLKIN;
			MPA_PL_GPIO: plOk = gpioFn_r == MPA_GP_CLKIN;
		endcase
		unique case (ccSel_r)
			MPA_CC_MCLK: ccOk = 1'b1;
			MPA_CC_BCLK: ccOk = !bclkMst_r;
			MPA_CC_GPIO: ccOk = gpioFn_r == MPA_GP_CLKIN;
			MPA_CC_PLL: ccOk = 1'b1;
		endcase
	end

	mpa_ref_sel #(.N(4)) u_plSel (
		.core_clk(core_clk),
		.rst(rst),
		.cand({gpioIn, dinIn, bclkIn, mclkIn}),
		.sel(plSel_r),
		.srcOk(plOk),
		.refOut(pllRefClk)
	);

	mpa_ref_sel #(.N(4)) u_ccSel (
		.core_clk(core_clk),
		.rst(rst),
		.cand({pllOutClk, gpioIn, bclkIn, mclkIn}),
		.sel(ccSel_r),
		.srcOk(ccOk),
		.refOut(convRefClk)
	);

	mpa_gp_in #(.N(`MPA_NUM_GPI)) u_gpIn (
		.core_clk(core_clk),
		.rst(rst),
		.pinLvl({sclkIn, gpioIn, dinIn}),
		.pinEn({sclkFn_r == MPA_SC_GPIN, gpioFn_r == MPA_GP_GPIN, dinFn_r == MPA_DI_GPIN}),
		.level(gpiLvl)
	);

	// Only one mode per pin exists, so interrupt and general output never share
	always_comb begin
		gpioOut_nxt = 1'b0;
		gpioOe_nxt = 1'b1;
		unique case (gpioFn_r)
			MPA_GP_GPOUT: gpioOut_nxt = gpoLvl_r[`MPA_GPO1];
			MPA_GP_IRQ_FIRST: gpioOut_nxt = firstIntr;
			MPA_GP_IRQ_SECOND: gpioOut_nxt = secondIntr;
			MPA_GP_SBCLKO: gpioOut_nxt = secBclkSrc;
			MPA_GP_SWCLKO: gpioOut_nxt = secWclkSrc;
			MPA_GP_AUXCLK: gpioOut_nxt = auxClk;
			default: gpioOe_nxt = 1'b0;
		endcase
	end

	always_comb begin
		misoOut_nxt = 1'b0;
		misoOe_nxt = 1'b1;
		unique case (misoFn_r)
			MPA_MS_CTRL: begin
				misoOut_nxt = ctrlMisoData;
				misoOe_nxt = ctrlMisoOe;
			end
			MPA_MS_GPOUT: misoOut_nxt = gpoLvl_r[`MPA_GPO2];
			MPA_MS_IRQ_FIRST: misoOut_nxt = firstIntr;
			MPA_MS_IRQ_SECOND: misoOut_nxt = secondIntr;
			MPA_MS_SBCLKO: misoOut_nxt = secBclkSrc;
			MPA_MS_SWCLKO: misoOut_nxt = secWclkSrc;
			MPA_MS_SDOUT: misoOut_nxt = secDoutSrc;
			MPA_MS_AUXCLK: misoOut_nxt = auxClk;
		endcase
	end

	// Pin drivers, registered so every output is clean from reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			gpioOut <= 1'b0;
			gpioOe <= 1'b0;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
			bclkOut <= 1'b0;
			bclkOe <= 1'b0;
			wclkOut <= 1'b0;
			wclkOe <= 1'b0;
		end else begin
			gpioOut <= gpioOut_nxt;
			gpioOe <= gpioOe_nxt;
			misoOut <= misoOut_nxt;
			misoOe <= misoOe_nxt;
			bclkOut <= bclkMst_r & masterBclk;
			bclkOe <= bclkMst_r;
			wclkOut <= wclkMst_r & masterWclk;
			wclkOe <= wclkMst_r;
		end
	end

	// Internal function inputs; GPIO wins when both pins claim the same secondary input
	always_ff @(posedge core_clk) begin
		if (rst) begin
			audioBclk <= 1'b0;
			audioWclk <= 1'b0;
			audioDin <= 1'b0;
			spiSclk <= 1'b0;
			secBclkIn <= 1'b0;
			secWclkIn <= 1'b0;
			secDinIn <= 1'b0;
		end else begin
			audioBclk <= !bclkMst_r & bclkIn;
			audioWclk <= !wclkMst_r & wclkIn;
			audioDin <= (dinFn_r == MPA_DI_AUDIO) & dinIn;
			spiSclk <= (sclkFn_r == MPA_SC_CTRL) & sclkIn;
			secBclkIn <= gpioFn_r == MPA_GP_SBCLKI ? gpioIn : (sclkFn_r == MPA_SC_SBCLKI) & sclkIn;
			secWclkIn <= gpioFn_r == MPA_GP_SWCLKI ? gpioIn : (sclkFn_r == MPA_SC_SWCLKI) & sclkIn;
			secDinIn <= gpioFn_r == MPA_GP_SDIN ? gpioIn : (sclkFn_r == MPA_SC_SDIN) & sclkIn;
		end
	end

	always_comb begin
		rdMux = '0;
		if (addrHit) begin
			case (addrLo)
				`MPA_ADDR_CLKSEL: begin
					rdMux[`MPA_CC_MSB:`MPA_CC_LSB] = ccSel_r;
					rdMux[`MPA_PL_MSB:`MPA_PL_LSB] = plSel_r;
				end
				`MPA_ADDR_GPIOFN: rdMux[`MPA_GPIOFN_MSB:`MPA_FN_LSB] = gpioFn_r;
				`MPA_ADDR_MISOFN: rdMux[`MPA_MISOFN_MSB:`MPA_FN_LSB] = misoFn_r;
				`MPA_ADDR_SCLKFN: rdMux[`MPA_SCLKFN_MSB:`MPA_FN_LSB] = sclkFn_r;
				`MPA_ADDR_DINFN: rdMux[`MPA_DINFN_MSB:`MPA_FN_LSB] = dinFn_r;
				`MPA_ADDR_DIR: begin
					rdMux[`MPA_DIR_BCLK] = bclkMst_r;
					rdMux[`MPA_DIR_WCLK] = wclkMst_r;
				end
				`MPA_ADDR_GPOLVL: rdMux[`MPA_GPO2:`MPA_GPO1] = gpoLvl_r;
				`MPA_ADDR_GPILVL: rdMux[`MPA_NUM_GPI-1:0] = gpiLvl;
				`MPA_ADDR_STATUS: begin
					rdMux[`MPA_ST_CC_OK] = ccOk;
					rdMux[`MPA_ST_PL_OK] = plOk;
				end
				default: ;
			endcase
		end
	end

	// Read data stands for exactly one cycle, zero otherwise
	always_ff @(posedge core_clk) begin
		if (rst) regRdData <= `MPA_RD_IDLE;
		else if (regRdEn) regRdData <= rdMux;
		else regRdData <= `MPA_RD_IDLE;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_setGpo1;
		regWrEn && addrHit && addrLo == `MPA_ADDR_GPOLVL;
	endsequence
	sequence s_gpoMode;
		gpioFn_r == MPA_GP_GPOUT;
	endsequence

	a_reset_defaults: assert property ($fell(rst) |-> ccSel_r == MPA_CC_MCLK
		&& dinFn_r == MPA_DI_AUDIO && !bclkMst_r && !wclkMst_r) else $error("reset defaults wrong");
	a_pll_source_gate: assert property (!plOk |=> !pllRefClk)
		else $error("PLL fed from unusable pin");
	a_mclk_shared: assert property (plSel_r == MPA_PL_MCLK && ccSel_r == MPA_CC_MCLK
		|=> pllRefClk == $past(mclkIn) && convRefClk == $past(mclkIn))
		else $error("master clock not shared");
	a_bclk_shared: assert property (plSel_r == MPA_PL_BCLK && ccSel_r == MPA_CC_BCLK
		&& !bclkMst_r |=> pllRefClk == $past(bclkIn) && convRefClk == $past(bclkIn)
		&& audioBclk == $past(bclkIn)) else $error("bit clock not shared");
	a_gpio_clk_shared: assert property (gpioFn_r == MPA_GP_CLKIN && plSel_r == MPA_PL_GPIO
		&& ccSel_r == MPA_CC_GPIO |=> pllRefClk == $past(gpioIn) && convRefClk == $past(gpioIn)
		&& !gpioOe) else $error("GPIO clock not shared");
	a_din_exclusive: assert property (dinFn_r != MPA_DI_AUDIO |=> !audioDin)
		else $error("data pin leaks to audio port");
	a_gpo_level: assert property (s_setGpo1 ##1 s_gpoMode
		|=> gpioOe && gpioOut == $past(regWrData[`MPA_GPO1], 2))
		else $error("GPIO output level wrong");
	a_gpo_not_int: assert property (s_gpoMode |=> gpioOut == $past(gpoLvl_r[`MPA_GPO1]))
		else $error("GPIO output carries interrupt");
	a_miso_gpo: assert property (misoFn_r == MPA_MS_GPOUT
		|=> misoOe && misoOut == $past(gpoLvl_r[`MPA_GPO2])) else $error("second output wrong");
	a_gpi_read: assert property (dinFn_r == MPA_DI_GPIN ##1 regRdEn && addrHit
		&& addrLo == `MPA_ADDR_GPILVL |=> regRdData[`MPA_GPI1] == $past(dinIn, 2))
		else $error("first input not readable");
	a_gpi2_level: assert property (gpioFn_r == MPA_GP_GPIN
		|=> gpiLvl[`MPA_GPI2] == $past(gpioIn) && !gpioOe) else $error("second input wrong");
	a_gpi3_level: assert property (sclkFn_r == MPA_SC_GPIN
		|=> gpiLvl[`MPA_GPI3] == $past(sclkIn) && !spiSclk) else $error("third input wrong");
	a_sec_dout: assert property (misoFn_r == MPA_MS_SDOUT
		|=> misoOe && misoOut == $past(secDoutSrc)) else $error("secondary data out wrong");
	a_int_route: assert property (gpioFn_r == MPA_GP_IRQ_SECOND
		|=> gpioOe && gpioOut == $past(secondIntr)) else $error("interrupt route wrong");
	a_conv_pll: assert property (ccSel_r == MPA_CC_PLL |=> convRefClk == $past(pllOutClk))
		else $error("converter clock not from PLL");
endmodule : mpa_pin_allocator
`default_nettype wire

/* File: verif/mpa_host_model.sv */
// Far-side model: host audio port and core sources driving the allocator inputs.
// Each level follows its own parity pattern of a counter, the bit clock wire only while undriven; freeze holds them still.
`timescale 1ns/1ps
`default_nettype none
module mpa_host_model (
	input wire logic core_clk,
	input wire logic freeze,
	input wire logic bclkOe,
	input wire logic bclkOut,
	output logic [16:0] lvl
);
	logic [4:0] cnt_r = 5'h00;
	logic [16:0] pat;

	always_ff @(posedge core_clk) begin
		if (!freeze) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	always_comb begin
		for (int i = 0; i < 17; i++) begin
			pat[i] = ^(cnt_r & 5'(i + 1));
		end
		lvl = pat;
		// Bit clock wire: device drive wins while it is master
		lvl[1] = bclkOe ? bclkOut : pat[1];
	end
endmodule : mpa_host_model
`default_nettype wire

/* File: verif/test_multifunction_pin_allocator.sv */
// Self-checking bench of the pin allocator: table of routings, then reads and reset.
// Assumes the host model of this folder and the default register port widths.
`timescale 1ns/1ps
`default_nettype none
module test_multifunction_pin_allocator;
	import mpa_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [4:0] o; logic [4:0] s;} mpa_row_t;
	// Output index o, source index s: 17 is constant 0, 18 constant 1
	localparam mpa_row_t ROWS [46] = '{
		'{8'h0f, 8'hff, 5'h01, 5'h00}, '{8'h0f, 8'hff, 5'h00, 5'h00},
		'{8'h0f, 8'hff, 5'h02, 5'h01}, '{8'h0f, 8'hff, 5'h03, 5'h02},
		'{8'h0f, 8'hff, 5'h04, 5'h03}, '{8'h00, 8'h05, 5'h01, 5'h01},
		'{8'h0f, 8'hff, 5'h05, 5'h05}, '{8'h0f, 8'hff, 5'h0b, 5'h0f},
		'{8'h0f, 8'hff, 5'h00, 5'h01}, '{8'h0f, 8'hff, 5'h02, 5'h01},
		'{8'h01, 8'h01, 5'h00, 5'h01}, '{8'h00, 8'h0e, 5'h01, 5'h04},
		'{8'h0f, 8'hff, 5'h00, 5'h04}, '{8'h00, 8'h03, 5'h01, 5'h06},
		'{8'h0f, 8'hff, 5'h00, 5'h00}, '{8'h04, 8'h02, 5'h00, 5'h00},
		'{8'h00, 8'h0b, 5'h00, 5'h03}, '{8'h04, 8'h01, 5'h00, 5'h11},
		'{8'h06, 8'h03, 5'h0c, 5'h10}, '{8'h01, 8'h02, 5'h09, 5'h12},
		'{8'h06, 8'h02, 5'h09, 5'h11},
		'{8'h0f, 8'hff, 5'h0a, 5'h12}, '{8'h02, 8'h01, 5'h0b, 5'h12},
		'{8'h0f, 8'hff, 5'h0c, 5'h12}, '{8'h01, 8'h04, 5'h09, 5'h09},
		'{8'h01, 8'h05, 5'h09, 5'h0a}, '{8'h01, 8'h06, 5'h09, 5'h0b},
		'{8'h01, 8'h07, 5'h09, 5'h0c}, '{8'h01, 8'h08, 5'h09, 5'h0e},
		'{8'h02, 8'h02, 5'h0b, 5'h09}, '{8'h02, 8'h03, 5'h0b, 5'h0a},
		'{8'h02, 8'h04, 5'h0b, 5'h0b}, '{8'h02, 8'h05, 5'h0b, 5'h0c},
		'{8'h02, 8'h06, 5'h0b, 5'h0d}, '{8'h02, 8'h07, 5'h0b, 5'h0e},
		'{8'h01, 8'h09, 5'h06, 5'h04}, '{8'h01, 8'h0a, 5'h07, 5'h04},
		'{8'h01, 8'h0b, 5'h08, 5'h04}, '{8'h01, 8'h00, 5'h0a, 5'h11},
		'{8'h03, 8'h02, 5'h06, 5'h05}, '{8'h03, 8'h03, 5'h07, 5'h05},
		'{8'h03, 8'h04, 5'h08, 5'h05}, '{8'h05, 8'h03, 5'h0d, 5'h07},
		'{8'h0f, 8'hff, 5'h0e, 5'h08}, '{8'h0f, 8'hff, 5'h0f, 5'h12},
		'{8'h0f, 8'hff, 5'h10, 5'h12}
	};
	logic core_clk, rst, regWrEn, regRdEn, freeze;
	logic [7:0] regAddr, regWrData, regRdData;
	logic bclkOut, bclkOe, wclkOut, wclkOe, gpioOut, gpioOe, misoOut, misoOe;
	logic pllRefClk, convRefClk, audioBclk, audioWclk, audioDin, spiSclk;
	logic secBclkIn, secWclkIn, secDinIn;
	logic [16:0] lvl;
	logic [18:0] src, srcPrev;
	logic [16:0] obs;
	int errCount = 0;
	int totalChecks = 0;

	assign src = {1'b1, 1'b0, lvl};
	assign obs = {wclkOe, bclkOe, wclkOut, bclkOut, misoOe, misoOut, gpioOe, gpioOut, secDinIn, secWclkIn,
		secBclkIn, spiSclk, audioDin, audioWclk, audioBclk, convRefClk, pllRefClk};

	mpa_host_model host_u (.core_clk(core_clk), .freeze(freeze), .bclkOe(bclkOe),
		.bclkOut(bclkOut), .lvl(lvl));

	mpa_pin_allocator #(.AW(8), .DW(8)) dut_u (
		.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.mclkIn(lvl[0]), .bclkIn(lvl[1]), .bclkOut(bclkOut), .bclkOe(bclkOe),
		.wclkIn(lvl[2]), .wclkOut(wclkOut), .wclkOe(wclkOe), .dinIn(lvl[3]),
		.gpioIn(lvl[4]), .gpioOut(gpioOut), .gpioOe(gpioOe), .sclkIn(lvl[5]),
		.misoOut(misoOut), .misoOe(misoOe), .pllOutClk(lvl[6]), .masterBclk(lvl[7]),
		.masterWclk(lvl[8]), .ctrlMisoData(lvl[15]), .ctrlMisoOe(lvl[16]),
		.firstIntr(lvl[9]), .secondIntr(lvl[10]), .secBclkSrc(lvl[11]),
		.secWclkSrc(lvl[12]), .secDoutSrc(lvl[13]), .auxClk(lvl[14]),
		.pllRefClk(pllRefClk), .convRefClk(convRefClk), .audioBclk(audioBclk),
		.audioWclk(audioWclk), .audioDin(audioDin), .spiSclk(spiSclk),
		.secBclkIn(secBclkIn), .secWclkIn(secWclkIn), .secDinIn(secDinIn));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Routed outputs lag their source by one edge
	always @(posedge core_clk) srcPrev <= src;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		@(negedge core_clk);
		chk(16'(regRdData), 16'(exp));
	endtask : rd

	task automatic results();
		$display("checks=%0d mismatches=%0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	initial begin
		#50000;
		errCount++;
		results();
	end

	initial begin
		rst = 1'b1;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		freeze = 1'b0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			repeat (2) @(posedge core_clk);
			repeat (6) begin
				@(negedge core_clk);
				chk(16'(obs[ROWS[i].o]), 16'(srcPrev[ROWS[i].s]));
			end
		end
		// General inputs read back with the pins held still
		freeze <= 1'b1;
		wr(8'h01, 8'h03);
		wr(8'h03, 8'h01);
		wr(8'h10, 8'hff);
		repeat (3) @(posedge core_clk);
		rd(8'h07, {5'h00, lvl[5], lvl[4], lvl[3]});
		rd(8'h08, 8'h01);
		rd(8'h00, 8'h0b);
		rd(8'h10, 8'h00);
		rd(8'h0f, 8'h00);
		// Second reset in mid-run brings every default back
		@(posedge core_clk);
		freeze <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk(16'(obs[16:1]), 16'h0000);
		chk(16'(obs[0]), 16'h0000);
		@(posedge core_clk);
		rst <= 1'b0;
		for (int a = 0; a < 7; a++) begin
			rd(8'(a), 8'h00);
		end
		repeat (2) @(negedge core_clk);
		chk(16'(convRefClk), 16'(srcPrev[0]));
		chk(16'(audioWclk), 16'(srcPrev[2]));
		results();
	end
endmodule : test_multifunction_pin_allocator
`default_nettype wire
